// [src/cmp_wake_pkg.sv]
`default_nettype none
package cmp_wake_pkg;
  // power modes of the core
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_GREEN,
    MODE_IDLE,
    MODE_SLEEP
  } power_mode_t;

  // register offsets on the plain port
  localparam logic [3:0] OFF_WUCR = 4'h0; // wake ctl + flag
  localparam logic [3:0] OFF_IEN = 4'h1; // irq enables + watchdog enable
  localparam logic [3:0] OFF_GIE = 4'h2; // global irq enable state
  localparam logic [3:0] OFF_STAT = 4'h3; // sticky event status
  localparam logic [3:0] OFF_MASK = 4'h4; // status mask
  localparam logic [3:0] OFF_PWR = 4'h5; // power state, read only

  // field positions
  localparam int BIT_CMP_FLAG = 0;
  localparam int BIT_CMP_WAKE_EN = 2;
  localparam int BIT_CMP_IRQ_EN = 0;
  localparam int BIT_WDOG_EN = 7;

  // sticky status bits
  localparam int EV_CMP_FLAG = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_VECTOR = 2;
  localparam int EV_RESET = 3;
  localparam int EV_W = 4;

  // addresses the sequencer is sent to
  localparam logic [7:0] IRQ_VECTOR_ADDR = 8'h08;
  localparam logic [7:0] RESET_ADDR = 8'h00;

  // reset values
  localparam logic [7:0] WUCR_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [EV_W-1:0] STAT_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
endpackage : cmp_wake_pkg
`default_nettype wire

// [src/cmp_event_pulse.sv]
`default_nettype none
// turns a level into a one-cycle change pulse, first sample is not a change
module cmp_event_pulse (
  input wire logic mclk,
  input wire logic rst,
  input wire logic level,
  output logic change
);
  typedef struct packed {
    logic seen;
    logic prev;
    logic chg;
  } edge_state_t;

  edge_state_t s_r, s_nxt;

  // compare against last sample; suppress the very first one after reset
  always_comb begin
    s_nxt = s_r;
    s_nxt.seen = 1'b1;
    s_nxt.prev = level;
    s_nxt.chg = s_r.seen && (level != s_r.prev);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign change = s_r.chg;
endmodule : cmp_event_pulse
`default_nettype wire

// [src/comparator_wake_interrupt_ctl.sv]
// Functional notes
// - asleep, both enables off: no wake
// - awake, irq enable off: no interrupt
// - asleep, only irq enable: flag, no wake
// - asleep, only wake enable: wake, next, no flag
// - globally disabled: flag, next instruction
// - disabled wake sets flag, no vector
// - globally enabled: flag, wake, vector 0x08
// - watchdog or low voltage: wake, reset 0x00
//
// The strobed register port and the register addresses are this design's own decisions.
`default_nettype none
module comparator_wake_interrupt_ctl
  import cmp_wake_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmp_out,
  input wire logic [1:0] power_mode,
  input wire logic global_irq_disable_instr,
  input wire logic global_irq_enable_instr,
  input wire logic watchdog_timeout,
  input wire logic low_voltage,
  output logic wake_req,
  output logic next_instr,
  output logic vector_req,
  output logic reset_req,
  output logic [7:0] jump_addr,
  output logic osc_run,
  output logic irq
);
  typedef struct packed {
    logic [7:0] wucr;
    logic [7:0] ien;
    logic gie;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [7:0] rdata;
    logic wake;
    logic next;
    logic vec;
    logic rstq;
    logic [7:0] jaddr;
    logic osc;
    logic irq;
  } ctl_state_t;

  ctl_state_t s_r, s_nxt;
  logic cmp_change;

  cmp_event_pulse u_edge (
    .mclk(mclk),
    .rst(rst),
    .level(cmp_out),
    .change(cmp_change)
  );

  function automatic logic is_asleep(input logic [1:0] m);
    return (m == MODE_SLEEP) || (m == MODE_IDLE);
  endfunction : is_asleep

  logic asleep, wake_en, irq_en, wd_hit, take_flag, take_wake;
  assign asleep = is_asleep(power_mode);
  assign wake_en = s_r.wucr[BIT_CMP_WAKE_EN];
  assign irq_en = s_r.ien[BIT_CMP_IRQ_EN];
  assign wd_hit = (watchdog_timeout && s_r.ien[BIT_WDOG_EN]) || low_voltage;
  // flag is set whenever the irq enable is on, asleep or not, except in a cycle that takes a reset dispatch
  assign take_flag = cmp_change && irq_en;
  // of the two comparator enables, only the wake enable can pull the core out of sleep or idle
  assign take_wake = cmp_change && asleep && wake_en;

  // dispatch decision, register access and sticky status
  always_comb begin
    logic [EV_W-1:0] ev;
    ev = '0;
    s_nxt = s_r;
    s_nxt.wake = 1'b0;
    s_nxt.next = 1'b0;
    s_nxt.vec = 1'b0;
    s_nxt.rstq = 1'b0;
    s_nxt.rdata = 8'h00;
    // instructions toggle the global enable; disable wins if both
    if (global_irq_enable_instr) begin
      s_nxt.gie = 1'b1;
    end
    if (global_irq_disable_instr) begin
      s_nxt.gie = 1'b0;
    end
    // software writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_WUCR: s_nxt.wucr = reg_wdata;
        OFF_IEN: s_nxt.ien = reg_wdata;
        OFF_GIE: s_nxt.gie = reg_wdata[0];
        OFF_STAT: s_nxt.stat = s_r.stat & ~reg_wdata[EV_W-1:0];
        OFF_MASK: s_nxt.mask = reg_wdata[EV_W-1:0];
        default: ;
      endcase
    end
    if (wd_hit) begin
      // reset outranks any comparator dispatch
      s_nxt.wake = asleep;
      s_nxt.rstq = 1'b1;
      s_nxt.jaddr = RESET_ADDR;
      s_nxt.osc = 1'b1;
      ev[EV_RESET] = 1'b1;
      ev[EV_WAKE] = asleep;
    end else if (take_flag || take_wake) begin
      // asleep with irq enable but no wake enable: flag only
      if (asleep && !wake_en) begin
        ev[EV_CMP_FLAG] = 1'b1;
      end else begin
        s_nxt.wake = asleep;
        s_nxt.osc = 1'b1;
        ev[EV_WAKE] = asleep;
        ev[EV_CMP_FLAG] = take_flag;
        if (take_flag && s_r.gie) begin
          s_nxt.vec = 1'b1;
          s_nxt.jaddr = IRQ_VECTOR_ADDR;
          ev[EV_VECTOR] = 1'b1;
        end else begin
          s_nxt.next = 1'b1;
        end
      end
    end
    if (ev[EV_CMP_FLAG]) begin
      s_nxt.wucr[BIT_CMP_FLAG] = 1'b1;
    end
    // oscillator stops while asleep unless woken
    if (asleep && !s_nxt.wake) begin
      s_nxt.osc = 1'b0;
    end else if (!asleep) begin
      s_nxt.osc = 1'b1;
    end
    // set wins over a write-one clear in the same cycle
    s_nxt.stat = s_nxt.stat | ev;
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_WUCR: s_nxt.rdata = s_r.wucr;
        OFF_IEN: s_nxt.rdata = s_r.ien;
        OFF_GIE: s_nxt.rdata = {7'h00, s_r.gie};
        OFF_STAT: s_nxt.rdata = {4'h0, s_r.stat};
        OFF_MASK: s_nxt.rdata = {4'h0, s_r.mask};
        OFF_PWR: s_nxt.rdata = {5'h00, s_r.osc, power_mode};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '{wucr: WUCR_RST, ien: IEN_RST, gie: 1'b0, stat: STAT_RST,
               mask: MASK_RST, rdata: 8'h00, wake: 1'b0, next: 1'b0,
               vec: 1'b0, rstq: 1'b0, jaddr: RESET_ADDR, osc: 1'b1,
               irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign wake_req = s_r.wake;
  assign next_instr = s_r.next;
  assign vector_req = s_r.vec;
  assign reset_req = s_r.rstq;
  assign jump_addr = s_r.jaddr;
  assign osc_run = s_r.osc;
  assign irq = s_r.irq;

  // checks
  chk_no_wake_off: assert property (@(posedge mclk) disable iff (rst)
    cmp_change && asleep && !wake_en && !wd_hit |=> !wake_req)
    else $error("comparator woke core with wake enable off");
  chk_no_irq_off: assert property (@(posedge mclk) disable iff (rst)
    cmp_change && !asleep && !irq_en && !wd_hit |=> !vector_req)
    else $error("vector taken with irq enable off");
  chk_flag_no_wake: assert property (@(posedge mclk) disable iff (rst)
    cmp_change && asleep && !wake_en && irq_en && !wd_hit
    |=> s_r.wucr[BIT_CMP_FLAG] && !wake_req)
    else $error("flag only case wrong");
  chk_wake_no_flag: assert property (@(posedge mclk) disable iff (rst)
    cmp_change && asleep && wake_en && !irq_en && !wd_hit
    |=> wake_req && next_instr && !vector_req)
    else $error("wake next instruction case wrong");
  chk_disabled_next: assert property (@(posedge mclk) disable iff (rst)
    cmp_change && irq_en && !s_r.gie && !wd_hit && (!asleep || wake_en)
    |=> next_instr && s_r.wucr[BIT_CMP_FLAG])
    else $error("disabled case did not continue");
  chk_disabled_novec: assert property (@(posedge mclk) disable iff (rst)
    next_instr |-> !vector_req && $past(!s_r.gie || !irq_en))
    else $error("vector during disabled case");
  chk_vector_addr: assert property (@(posedge mclk) disable iff (rst)
    cmp_change && irq_en && s_r.gie && !wd_hit && (!asleep || wake_en)
    |=> vector_req && jump_addr == 8'h08 && wake_req == $past(asleep))
    else $error("vector dispatch wrong");
  chk_reset_addr: assert property (@(posedge mclk) disable iff (rst)
    wd_hit |=> reset_req && jump_addr == 8'h00 && wake_req == $past(asleep))
    else $error("reset dispatch wrong");
  cov_vector: cover property (@(posedge mclk) disable iff (rst) vector_req);
  cov_wake: cover property (@(posedge mclk) disable iff (rst)
    wake_req && next_instr);
  cov_reset: cover property (@(posedge mclk) disable iff (rst) reset_req);
  cov_irq: cover property (@(posedge mclk) disable iff (rst) irq);
endmodule : comparator_wake_interrupt_ctl
`default_nettype wire

// [dv/core_model.sv]
`default_nettype none
// stand-in for the core sequencer: it holds the power mode and leaves
// low power on any wake or reset request, as the real core would
module core_model
  import cmp_wake_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode_load,
  input wire logic [1:0] mode_set,
  input wire logic wake_req,
  input wire logic reset_req,
  output logic [1:0] power_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  // a load from the bench wins, so a new mode is never lost to a late wake
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) power_mode <= MODE_NORMAL;
    else if (mode_load) power_mode <= mode_set;
    else if (wake_req || reset_req) power_mode <= MODE_NORMAL;
  end
endmodule : core_model
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
module tb_top
  import cmp_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cmp_out = 1'b0;
  logic dis_p = 1'b0;
  logic en_p = 1'b0;
  logic wdog = 1'b0;
  logic lowv = 1'b0;
  logic mode_load = 1'b0;
  logic [1:0] mode_set = 2'h0;
  logic [1:0] power_mode;
  logic [7:0] reg_rdata;
  logic [7:0] jump_addr;
  logic wake_req, next_instr, vector_req, reset_req, osc_run, irq;
  logic [3:0] cap;
  logic [11:0] t;
  int miscompares = 0;
  int n_tests = 0;
  // {mode, wake en, irq en, global en, flag, wake/next/vector/reset}
  logic [11:0] cases [8] = '{12'h600, 12'h000, 12'h4a0, 12'h70c,
    12'h2a4, 12'h7ac, 12'h0e2, 12'h5ea};

  always #5 mclk = ~mclk;

  comparator_wake_interrupt_ctl i_comparator_wake_interrupt_ctl (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_out(cmp_out), .power_mode(power_mode),
    .global_irq_disable_instr(dis_p), .global_irq_enable_instr(en_p),
    .watchdog_timeout(wdog), .low_voltage(lowv), .wake_req(wake_req),
    .next_instr(next_instr), .vector_req(vector_req),
    .reset_req(reset_req), .jump_addr(jump_addr), .osc_run(osc_run),
    .irq(irq));
  core_model i_core_model (.mclk(mclk), .rst(rst), .mode_load(mode_load),
    .mode_set(mode_set), .wake_req(wake_req), .reset_req(reset_req),
    .power_mode(power_mode));

  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // an idle edge after each strobe keeps one assignment per time step
  task automatic wr(logic [3:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(logic [3:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge mclk);
  endtask : rd

  task automatic setm(logic [1:0] m);
    mode_set <= m;
    mode_load <= 1'b1;
    @(posedge mclk);
    mode_load <= 1'b0;
    @(posedge mclk);
  endtask : setm

  task automatic gie(logic v);
    en_p <= v;
    dis_p <= ~v;
    @(posedge mclk);
    en_p <= 1'b0;
    dis_p <= 1'b0;
    @(posedge mclk);
  endtask : gie

  // one event, then gather every dispatch pulse over a fixed window
  task automatic fire(int k);
    cap = 4'h0;
    if (k == 0) cmp_out <= ~cmp_out;
    if (k == 1) wdog <= 1'b1;
    if (k == 2) lowv <= 1'b1;
    @(posedge mclk);
    wdog <= 1'b0;
    lowv <= 1'b0;
    repeat (5) begin
      #1 cap = cap | {wake_req, next_instr, vector_req, reset_req};
      @(posedge mclk);
    end
  endtask : fire

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(OFF_WUCR, WUCR_RST);
    rd(4'hf, 8'h00);
    for (int i = 0; i < 8; i++) begin
      t = cases[i];
      setm(t[10:9]);
      wr(OFF_WUCR, {5'h0, t[8], 2'h0});
      wr(OFF_IEN, {7'h0, t[7]});
      gie(t[6]);
      fire(0);
      chk("dispatch", {4'h0, cap}, {4'h0, t[3:0]});
      if (t[10] && !t[3]) chk("osc", {7'h0, osc_run}, 8'h00);
      rd(OFF_WUCR, {5'h0, t[8], 1'b0, t[5]});
    end
    chk("vector addr", jump_addr, IRQ_VECTOR_ADDR);
    rd(OFF_GIE, 8'h01);
    // status is sticky; the level output follows only unmasked bits
    rd(OFF_STAT, 8'h07);
    chk("irq masked", {7'h0, irq}, 8'h00);
    wr(OFF_MASK, 8'h04);
    rd(OFF_MASK, 8'h04);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(OFF_STAT, 8'h04);
    rd(OFF_STAT, 8'h03);
    chk("irq clear", {7'h0, irq}, 8'h00);
    setm(MODE_SLEEP);
    wr(OFF_IEN, 8'h00);
    rd(OFF_PWR, 8'h03);
    fire(1);
    chk("wdog off", {4'h0, cap}, 8'h00);
    wr(OFF_IEN, 8'h80);
    fire(1);
    chk("wdog", {4'h0, cap}, 8'h09);
    chk("reset addr", jump_addr, RESET_ADDR);
    setm(MODE_GREEN);
    fire(2);
    chk("low volt", {4'h0, cap}, 8'h01);
    close_out();
  end

  // a hang counts as a mismatch and ends the run
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
